// >>> fixed_cycle_interval_timer.sv
// interval timer core with its i2c register port and irq pins
`include "tmr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module fixed_cycle_interval_timer #(
    parameter logic [15:0] TICK_PRE_CYC = 16'(`TMR_TICK4K_CYC),
    parameter logic [17:0] REL_SLOW_CYC = 18'(`TMR_REL_SLOW_CYC),
    parameter logic [6:0] DEV_ADDR = `TMR_DEV_ADDR
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // i2c pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // other interrupt sources sharing the pins
    input wire logic other_irq_one,
    input wire logic other_irq_two,
    // open-drain interrupt pins
    output logic interrupt_pin_one_out,
    output logic interrupt_pin_one_oe,
    output logic interrupt_pin_two_out,
    output logic interrupt_pin_two_oe
);
    import tmr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // declarations
    logic [1:0] pin_q;
    logic scl_s;
    logic sda_s;
    logic scl_d_ff;
    logic sda_d_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    i2c_st_e st_ff;
    logic [3:0] bit_ff;
    logic [7:0] sh_ff;
    logic rw_ff;
    logic nack_ff;
    logic sda_oe_ff;
    logic [7:0] ptr_ff;
    logic wr_stb;
    logic [7:0] rd_data;
    logic [15:0] preset_ff;
    logic [7:0] ext_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] route_ff;
    logic tf_ff;
    logic [15:0] cnt_ff;
    logic timer_enable_bit;
    src_sel_t src_sel;
    logic timer_irq_enable;
    logic timer_freeze_bit;
    logic stop_bit;
    logic timer_irq_route;
    logic te_start;
    logic tf_clr;
    logic tie_clr;
    logic frozen;
    logic tick_sel;
    logic tick_go;
    logic tmr_evt;
    logic irq_low_ff;
    logic [17:0] rel_ff;
    logic pin1_ff;
    logic pin2_ff;
    logic [17:0] irq_age_ff;
    tick_if ticks ();

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and tick source
    pin_sync u_sync (
        .clk(clk),
        .srst(srst),
        .pin_raw({scl, sda_in}),
        .pin_q(pin_q)
    );

    tick_divider #(
        .PRE_CYC(TICK_PRE_CYC)
    ) u_div (
        .clk(clk),
        .srst(srst),
        .ticks(ticks)
    );

    assign scl_s = pin_q[1];
    assign sda_s = pin_q[0];

    // previous values for edge and condition detection
    always_ff @(posedge clk) begin
        if (srst) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d_ff;
    assign scl_fall = !scl_s && scl_d_ff;
    assign start_cond = scl_s && scl_d_ff && sda_d_ff && !sda_s;
    assign stop_cond = scl_s && scl_d_ff && !sda_d_ff && sda_s;

    ////////////////////////////////////////////////////////////////////
    // i2c slave state machine
    always_ff @(posedge clk) begin
        if (srst || stop_cond) begin
            st_ff <= S_IDLE;
            sda_oe_ff <= 1'b0;
            bit_ff <= 4'h0;
        end else if (start_cond) begin
            st_ff <= S_DEV;
            sda_oe_ff <= 1'b0;
            bit_ff <= 4'h0;
        end else begin
            case (st_ff)
                S_DEV, S_REG, S_WR: begin
                    if (scl_rise) begin
                        sh_ff <= {sh_ff[6:0], sda_s};
                        bit_ff <= bit_ff + 4'h1;
                    end else if (scl_fall && bit_ff == 4'h8) begin
                        bit_ff <= 4'h0;
                        if (st_ff == S_DEV && sh_ff[7:1] != DEV_ADDR) begin
                            st_ff <= S_IDLE;
                        end else begin
                            sda_oe_ff <= 1'b1;
                            if (st_ff == S_DEV) begin
                                rw_ff <= sh_ff[0];
                                st_ff <= S_DACK;
                            end else if (st_ff == S_REG) begin
                                st_ff <= S_RACK;
                            end else begin
                                st_ff <= S_WACK;
                            end
                        end
                    end
                end
                S_DACK: begin
                    if (scl_fall && rw_ff) begin
                        st_ff <= S_RD;
                        sh_ff <= rd_data;
                        sda_oe_ff <= !rd_data[7];
                    end else if (scl_fall) begin
                        st_ff <= S_REG;
                        sda_oe_ff <= 1'b0;
                    end
                end
                S_RACK, S_WACK: begin
                    if (scl_fall) begin
                        st_ff <= S_WR;
                        sda_oe_ff <= 1'b0;
                    end
                end
                S_RD: begin
                    if (scl_fall && bit_ff == 4'h7) begin
                        st_ff <= S_RDACK;
                        sda_oe_ff <= 1'b0;
                        bit_ff <= 4'h0;
                    end else if (scl_fall) begin
                        sh_ff <= {sh_ff[6:0], 1'b0};
                        sda_oe_ff <= !sh_ff[6];
                        bit_ff <= bit_ff + 4'h1;
                    end
                end
                S_RDACK: begin
                    if (scl_rise) begin
                        nack_ff <= sda_s;
                    end else if (scl_fall && nack_ff) begin
                        st_ff <= S_IDLE;
                    end else if (scl_fall) begin
                        st_ff <= S_RD;
                        sh_ff <= rd_data;
                        sda_oe_ff <= !rd_data[7];
                    end
                end
                default: begin
                    st_ff <= S_IDLE;
                end
            endcase
        end
    end

    assign sda_oe = sda_oe_ff;
    assign sda_out = 1'b0;

    // register pointer with auto increment
    always_ff @(posedge clk) begin
        if (srst) begin
            ptr_ff <= 8'h00;
        end else if (st_ff == S_REG && scl_fall && bit_ff == 4'h8) begin
            ptr_ff <= sh_ff;
        end else if ((st_ff == S_WACK && scl_fall) ||
                     (st_ff == S_RD && scl_fall && bit_ff == 4'h7)) begin
            ptr_ff <= ptr_ff + 8'h01;
        end
    end

    // write takes effect at the ack clock rising edge
    assign wr_stb = (st_ff == S_WACK) && scl_rise;

    ////////////////////////////////////////////////////////////////////
    // register file
    always_ff @(posedge clk) begin
        if (srst) begin
            preset_ff <= {`TMR_RESET_BYTE, `TMR_RESET_BYTE};
            ext_ff <= `TMR_RESET_BYTE;
            ctrl_ff <= `TMR_RESET_BYTE;
            route_ff <= `TMR_RESET_BYTE;
        end else if (wr_stb) begin
            if (ptr_ff == `TMR_REG_PRESET_LO) begin
                preset_ff[7:0] <= sh_ff;
            end else if (ptr_ff == `TMR_REG_PRESET_HI) begin
                preset_ff[15:8] <= sh_ff;
            end else if (ptr_ff == `TMR_REG_EXT) begin
                ext_ff <= sh_ff;
            end else if (ptr_ff == `TMR_REG_CTRL) begin
                ctrl_ff <= sh_ff & `TMR_CTRL_WMASK;
            end else if (ptr_ff == `TMR_REG_ROUTE) begin
                route_ff <= sh_ff & `TMR_ROUTE_WMASK;
            end
        end
    end

    assign timer_enable_bit = ext_ff[`TMR_TE_BIT];
    assign src_sel = ext_ff[2:0];
    assign timer_irq_enable = ctrl_ff[`TMR_TIE_BIT];
    assign timer_freeze_bit = ctrl_ff[`TMR_TIMER_FREEZE_BIT_BIT];
    assign stop_bit = ctrl_ff[`TMR_STOP_BIT];
    assign timer_irq_route = route_ff[`TMR_ROUTE_BIT];

    // write side effects decoded from the strobe
    assign te_start = wr_stb && ptr_ff == `TMR_REG_EXT &&
                      sh_ff[`TMR_TE_BIT] && !timer_enable_bit;
    assign tf_clr = wr_stb && ptr_ff == `TMR_REG_FLAGS &&
                    !sh_ff[`TMR_TF_BIT];
    assign tie_clr = wr_stb && ptr_ff == `TMR_REG_CTRL &&
                     !sh_ff[`TMR_TIE_BIT];

    // read mux, counter bytes follow the enable
    always_comb begin
        rd_data = 8'h00;
        if (ptr_ff == `TMR_REG_PRESET_LO) begin
            rd_data = timer_enable_bit ? cnt_ff[7:0] : preset_ff[7:0];
        end else if (ptr_ff == `TMR_REG_PRESET_HI) begin
            rd_data = timer_enable_bit ? cnt_ff[15:8] : preset_ff[15:8];
        end else if (ptr_ff == `TMR_REG_EXT) begin
            rd_data = ext_ff;
        end else if (ptr_ff == `TMR_REG_FLAGS) begin
            rd_data[`TMR_TF_BIT] = tf_ff;
        end else if (ptr_ff == `TMR_REG_CTRL) begin
            rd_data = ctrl_ff;
        end else if (ptr_ff == `TMR_REG_ROUTE) begin
            rd_data = route_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // source tick selection and freeze
    always_comb begin
        tick_sel = 1'b0;
        case (src_sel)
            `TMR_SRC_4K: tick_sel = ticks.t4k;
            `TMR_SRC_64: tick_sel = ticks.t64;
            `TMR_SRC_1S: tick_sel = ticks.t1s;
            `TMR_SRC_1M: tick_sel = ticks.t1m;
            `TMR_SRC_1H: tick_sel = ticks.t1h;
            default: tick_sel = 1'b0;
        endcase
    end

    // global stop freezes all but the fastest source
    assign frozen = stop_bit ? (src_sel != `TMR_SRC_4K) : timer_freeze_bit;
    assign tick_go = timer_enable_bit && !frozen && tick_sel;
    assign tmr_evt = tick_go && cnt_ff == 16'h0001;

    // down counter with automatic reload
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_ff <= 16'h0000;
        end else if (te_start) begin
            cnt_ff <= preset_ff;
        end else if (tick_go) begin
            cnt_ff <= (cnt_ff <= 16'h0001) ? preset_ff
                                           : cnt_ff - 16'h0001;
        end
    end

    // event flag, a new event beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            tf_ff <= 1'b0;
        end else if (tmr_evt) begin
            tf_ff <= 1'b1;
        end else if (tf_clr) begin
            tf_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt low period, auto release, kept through te clear
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_low_ff <= 1'b0;
            rel_ff <= 18'h00000;
        end else if (tie_clr) begin
            irq_low_ff <= 1'b0;
        end else if (tmr_evt && timer_irq_enable) begin
            irq_low_ff <= 1'b1;
            rel_ff <= (src_sel == `TMR_SRC_4K) ?
                      18'(`TMR_REL_FAST_CYC) : REL_SLOW_CYC;
        end else if (irq_low_ff) begin
            if (rel_ff <= 18'h00001) begin
                irq_low_ff <= 1'b0;
            end else begin
                rel_ff <= rel_ff - 18'h00001;
            end
        end
    end

    // routing onto the shared open-drain pins
    always_ff @(posedge clk) begin
        if (srst) begin
            pin1_ff <= 1'b0;
            pin2_ff <= 1'b0;
        end else begin
            pin1_ff <= (irq_low_ff && timer_irq_route) || other_irq_one;
            pin2_ff <= (irq_low_ff && !timer_irq_route) || other_irq_two;
        end
    end

    assign interrupt_pin_one_oe = pin1_ff;
    assign interrupt_pin_two_oe = pin2_ff;
    assign interrupt_pin_one_out = 1'b0;
    assign interrupt_pin_two_out = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // checks
    always_ff @(posedge clk) begin
        if (srst || !irq_low_ff || (tmr_evt && timer_irq_enable)) begin
            irq_age_ff <= 18'h00000;
        end else begin
            irq_age_ff <= irq_age_ff + 18'h00001;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    AST_TF_SET: assert property (tmr_evt |=> tf_ff)
        else $error("event flag not set by timer event");
    AST_TF_HOLD: assert property (tf_ff && !tf_clr |=> tf_ff)
        else $error("event flag dropped without a clear");
    AST_IRQ_ON: assert property (
        tmr_evt && timer_irq_enable && !tie_clr |=> irq_low_ff)
        else $error("interrupt not asserted on event");
    AST_IRQ_OFF: assert property (
        !timer_irq_enable && !irq_low_ff |=> !irq_low_ff)
        else $error("interrupt raised while irq enable is clear");
    AST_REL_BOUND: assert property (
        irq_low_ff |-> irq_age_ff < ((src_sel == `TMR_SRC_4K) ?
                                     18'(`TMR_REL_FAST_CYC) : REL_SLOW_CYC))
        else $error("interrupt low time too long");
    AST_TE_KEEP: assert property (
        irq_low_ff && !tie_clr && rel_ff > 18'h00001 |=> irq_low_ff)
        else $error("interrupt released early");
    AST_TE_LOAD: assert property (
        te_start |=> cnt_ff == $past(preset_ff) && timer_enable_bit)
        else $error("start did not load the preset");
    AST_FREEZE: assert property (
        frozen && !te_start |=> cnt_ff == $past(cnt_ff))
        else $error("count moved while frozen");
    AST_WRAP: assert property (
        tick_go && cnt_ff == 16'h0001 && !te_start
        |=> cnt_ff == $past(preset_ff) && tf_ff)
        else $error("no reload and flag at end of count");
    AST_READ_PRESET: assert property (
        !timer_enable_bit && ptr_ff == `TMR_REG_PRESET_HI
        |-> rd_data == preset_ff[15:8])
        else $error("preset not read back while disabled");
    AST_ROUTE: assert property (
        irq_low_ff && $stable(timer_irq_route) ##1 irq_low_ff
        |-> interrupt_pin_one_oe == $past(timer_irq_route)
            && (interrupt_pin_two_oe || $past(timer_irq_route)))
        else $error("interrupt on the wrong pin");
endmodule
`default_nettype wire

// >>> tmr_cfg.svh
// constants for the fixed-cycle interval timer
// Contract
// - 16-bit preset in two adjacent bytes
// - read preset when disabled, live count otherwise
// - three-bit source select, five tick rates
// - auto release: 122 us fast, 7.813 ms else
// - first period may be one tick short
// - readback only at selected tick resolution
// - clearing enable keeps low interrupt pin
// - enable rising edge loads preset, starts count
// - event flag set on event, held
// - writing zero clears flag, one ignored
// - irq enable set: event drives pin low
// - irq enable clear: no irq, releases pin
// - freeze bit pauses, resume from frozen value; code ignores it under global stop, so the 4K source keeps counting
// - global stop freezes slow sources
// - route bit: zero pin two, one pin one
// - count starts at ack clock rising edge
// - event at 0001h to 0000h, reload, repeat
// - interrupt releases without host action
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
`define TMR_REG_PRESET_LO 8'h1b
`define TMR_REG_PRESET_HI 8'h1c
`define TMR_REG_EXT 8'h1d
`define TMR_REG_FLAGS 8'h1e
`define TMR_REG_CTRL 8'h1f
`define TMR_REG_ROUTE 8'h32
`define TMR_TE_BIT 4
`define TMR_TF_BIT 4
`define TMR_STOP_BIT 6
`define TMR_TIE_BIT 4
`define TMR_TIMER_FREEZE_BIT_BIT 2
`define TMR_ROUTE_BIT 2
`define TMR_CTRL_WMASK 8'h7c
`define TMR_ROUTE_WMASK 8'h07
`define TMR_RESET_BYTE 8'h00
`define TMR_SRC_4K 3'h0
`define TMR_SRC_64 3'h1
`define TMR_SRC_1S 3'h2
`define TMR_SRC_1M 3'h3
`define TMR_SRC_1H 3'h4
`define TMR_CLK_HZ 25000000
`define TMR_CLK_MHZ 25
`define TMR_TICK_HZ 4096
`define TMR_TICK4K_CYC (`TMR_CLK_HZ / `TMR_TICK_HZ)
`define TMR_DIV_64_LAST 6'd63
`define TMR_DIV_60_LAST 6'd59
`define TMR_REL_FAST_NS 122000
`define TMR_REL_SLOW_NS 7813000
`define TMR_REL_FAST_CYC ((`TMR_REL_FAST_NS * `TMR_CLK_MHZ) / 1000)
`define TMR_REL_SLOW_CYC ((`TMR_REL_SLOW_NS * `TMR_CLK_MHZ) / 1000)
`define TMR_REL_W 18
`define TMR_DEV_ADDR 7'h40
`endif

// >>> tmr_pkg.sv
// types shared by the interval timer modules
`default_nettype none
package tmr_pkg;
    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_DEV = 9'h002,
        S_DACK = 9'h004,
        S_REG = 9'h008,
        S_RACK = 9'h010,
        S_WR = 9'h020,
        S_WACK = 9'h040,
        S_RD = 9'h080,
        S_RDACK = 9'h100
    } i2c_st_e;
    typedef logic [2:0] src_sel_t;
endpackage
`default_nettype wire

// >>> tick_if.sv
// tick enable pulses from the divider to the timer core
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
    logic t4k;
    logic t64;
    logic t1s;
    logic t1m;
    logic t1h;
    modport src (output t4k, t64, t1s, t1m, t1h);
    modport dst (input t4k, t64, t1s, t1m, t1h);
endinterface
`default_nettype wire

// >>> pin_sync.sv
// two-flop synchroniser for the bus pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // raw pins and synchronised copies
    input wire logic [1:0] pin_raw,
    output logic [1:0] pin_q
);
    logic [1:0] meta_ff;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_ff <= 2'h3;
            pin_q <= 2'h3;
        end else begin
            meta_ff <= pin_raw;
            pin_q <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// >>> tick_divider.sv
// divider chain making the five source tick pulses
`include "tmr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter logic [15:0] PRE_CYC = 16'(`TMR_TICK4K_CYC)
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // tick pulses
    tick_if.src ticks
);
    import tmr_pkg::*;
    logic [15:0] pre_ff;
    logic [5:0] d64_ff;
    logic [5:0] d1s_ff;
    logic [5:0] d1m_ff;
    logic [5:0] d1h_ff;

    // wrap a stage counter after its last count
    function automatic logic [5:0] step(input logic [5:0] c,
                                        input logic [5:0] lim);
        step = (c == lim) ? 6'h00 : c + 6'h01;
    endfunction

    // free-running chain, never reset by a start
    always_ff @(posedge clk) begin
        if (srst) begin
            pre_ff <= 16'h0000;
            d64_ff <= 6'h00;
            d1s_ff <= 6'h00;
            d1m_ff <= 6'h00;
            d1h_ff <= 6'h00;
            ticks.t4k <= 1'b0;
            ticks.t64 <= 1'b0;
            ticks.t1s <= 1'b0;
            ticks.t1m <= 1'b0;
            ticks.t1h <= 1'b0;
        end else begin
            pre_ff <= (pre_ff == PRE_CYC - 16'h0001) ? 16'h0000
                                                     : pre_ff + 16'h0001;
            ticks.t4k <= (pre_ff == PRE_CYC - 16'h0001);
            ticks.t64 <= ticks.t4k && d64_ff == `TMR_DIV_64_LAST;
            ticks.t1s <= ticks.t64 && d1s_ff == `TMR_DIV_64_LAST;
            ticks.t1m <= ticks.t1s && d1m_ff == `TMR_DIV_60_LAST;
            ticks.t1h <= ticks.t1m && d1h_ff == `TMR_DIV_60_LAST;
            if (ticks.t4k) d64_ff <= step(d64_ff, `TMR_DIV_64_LAST);
            if (ticks.t64) d1s_ff <= step(d1s_ff, `TMR_DIV_64_LAST);
            if (ticks.t1s) d1m_ff <= step(d1m_ff, `TMR_DIV_60_LAST);
            if (ticks.t1m) d1h_ff <= step(d1h_ff, `TMR_DIV_60_LAST);
        end
    end
endmodule
`default_nettype wire

// >>> i2c_host.sv
// i2c host model driving the timer's register port
`timescale 1ns/1ps
`default_nettype none
module i2c_host #(
    parameter logic [6:0] ADDR = 7'h40
) (
    // clock
    input wire logic clk,
    // bus lines, sda_rel high lets the pull-up win
    output logic scl,
    output logic sda_rel,
    input wire logic sda_line
);
    int nacks = 0;
    // idle bus: both lines high, scl still between frames
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // wait n clocks, then step just off the edge
    task automatic gap(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one bit: data set while scl low, sampled mid high
    task automatic bit_x(input logic b, output logic r);
        sda_rel = b;
        gap(2);
        scl = 1'b1;
        gap(2);
        r = sda_line;
        gap(2);
        scl = 1'b0;
        gap(2);
    endtask
    // start or repeated start
    task automatic start();
        sda_rel = 1'b1;
        gap(2);
        scl = 1'b1;
        gap(2);
        sda_rel = 1'b0;
        gap(4);
        scl = 1'b0;
        gap(2);
    endtask
    // stop, bus left idle
    task automatic stop();
        sda_rel = 1'b0;
        gap(2);
        scl = 1'b1;
        gap(4);
        sda_rel = 1'b1;
        gap(4);
    endtask
    // byte out, ack expected from the device
    task automatic byte_w(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        if (r !== 1'b0) begin
            nacks++;
        end
    endtask
    // register write; setting te from clear starts a count at its ack clock
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start();
        byte_w({ADDR, 1'b0});
        byte_w(a);
        byte_w(d);
        stop();
    endtask
    // register read, single byte closed by nack
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic r;
        start();
        byte_w({ADDR, 1'b0});
        byte_w(a);
        start();
        byte_w({ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, d[i]);
        end
        bit_x(1'b1, r);
        stop();
    endtask
    // live count: read until two reads agree
    task automatic rd_stable(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] p;
        rd(a, p);
        rd(a, d);
        while (d !== p) begin
            p = d;
            rd(a, d);
        end
    endtask
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the interval timer
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic oth1 = 1'b0;
    logic oth2 = 1'b0;
    logic scl, sda_rel, sda_line, sda_out, sda_oe;
    logic p1o, p1e, p2o, p2e;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    // wired-and of the sda drivers with pull-up
    assign sda_line = sda_rel & (sda_out | ~sda_oe);
    // 25 MHz clock
    always #20 clk = ~clk;
    i2c_host host_u (.clk(clk), .scl(scl), .sda_rel(sda_rel),
        .sda_line(sda_line));
    fixed_cycle_interval_timer #(.TICK_PRE_CYC(16'd4),
        .REL_SLOW_CYC(18'd20)) dut_u (.clk(clk), .srst(srst), .scl(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .other_irq_one(oth1), .other_irq_two(oth2),
        .interrupt_pin_one_out(p1o), .interrupt_pin_one_oe(p1e),
        .interrupt_pin_two_out(p2o), .interrupt_pin_two_oe(p2e));
    ////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // wait for pin two low, then measure its low time
    task automatic pulse(output int w);
        int n;
        n = 0;
        w = 0;
        while (p2e !== 1'b1 && n < 6000) begin
            host_u.gap(1);
            n++;
        end
        while (p2e === 1'b1 && w < 4000) begin
            host_u.gap(1);
            w++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // register storage, masks and unmapped address
    task automatic t_regs();
        logic [7:0] d;
        oth1 = 1'b1;
        host_u.gap(3);
        check(p1e, 1'b1);
        check(p2e, 1'b0);
        oth1 = 1'b0;
        oth2 = 1'b1;
        host_u.gap(3);
        check(p2e, 1'b1);
        check({sda_out, p1o, p2o}, 3'h0);
        oth2 = 1'b0;
        host_u.wr(8'h1d, 8'h00);
        host_u.wr(8'h1b, 8'ha5);
        host_u.wr(8'h1c, 8'h5a);
        host_u.rd(8'h1b, d);
        check(d, 8'ha5);
        host_u.rd(8'h1c, d);
        check(d, 8'h5a);
        host_u.wr(8'h32, 8'hff);
        host_u.rd(8'h32, d);
        check(d, 8'h07);
        host_u.wr(8'h1f, 8'hff);
        host_u.rd(8'h1f, d);
        check(d, 8'h7c);
        host_u.wr(8'h40, 8'hff);
        host_u.rd(8'h40, d);
        check(d, 8'h00);
        host_u.wr(8'h1f, 8'h00);
    endtask
    // event on pin one; flag, enable and irq enable clears
    task automatic t_irq();
        logic [7:0] d;
        host_u.wr(8'h1b, 8'h05);
        host_u.wr(8'h1c, 8'h00);
        host_u.wr(8'h1f, 8'h10);
        host_u.wr(8'h32, 8'h04);
        host_u.wr(8'h1d, 8'h10);
        host_u.rd_stable(8'h1c, d);
        check(d, 8'h00);
        check(p1e, 1'b1);
        check(p2e, 1'b0);
        host_u.wr(8'h1d, 8'h00);
        host_u.rd(8'h1e, d);
        check(d[4], 1'b1);
        check(p1e, 1'b1);
        host_u.wr(8'h1e, 8'h00);
        host_u.wr(8'h1e, 8'h10);
        host_u.rd(8'h1e, d);
        check(d[4], 1'b0);
        check(p1e, 1'b1);
        host_u.wr(8'h1f, 8'h00);
        host_u.gap(2);
        check(p1e, 1'b0);
    endtask
    // release times on pin two, then both freezes
    task automatic t_release();
        int w;
        logic [7:0] d;
        logic [7:0] e;
        host_u.wr(8'h32, 8'h00);
        host_u.wr(8'h1b, 8'h00);
        host_u.wr(8'h1c, 8'h04);
        host_u.wr(8'h1f, 8'h10);
        host_u.wr(8'h1d, 8'h10);
        pulse(w);
        check(16'(w >= 3049 && w <= 3051), 16'h0001);
        host_u.wr(8'h1d, 8'h00);
        host_u.wr(8'h1b, 8'h01);
        host_u.wr(8'h1c, 8'h00);
        host_u.wr(8'h1d, 8'h11);
        pulse(w);
        check(16'(w >= 19 && w <= 21), 16'h0001);
        for (int k = 0; k < 2; k++) begin
            host_u.wr(8'h1f, (k == 0) ? 8'h14 : 8'h50);
            host_u.gap(100);
            pulse(w);
            check(16'(w), 16'h0000);
        end
        // fastest source keeps running under global stop
        host_u.wr(8'h1d, 8'h00);
        host_u.wr(8'h1b, 8'h08);
        host_u.wr(8'h1c, 8'h00);
        host_u.wr(8'h1d, 8'h10);
        host_u.gap(40);
        check(p2e, 1'b1);
        // timer freeze holds the live count between two reads
        host_u.wr(8'h1f, 8'h14);
        host_u.rd(8'h1b, d);
        host_u.gap(16);
        host_u.rd(8'h1b, e);
        check(e, d);
        check(16'(d >= 8'h01 && d <= 8'h08), 16'h0001);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            fails++;
            summarize();
        end
    end
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        #1;
        srst = 1'b0;
        host_u.gap(6);
        t_regs();
        t_irq();
        t_release();
        check(16'(host_u.nacks), 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire
